/* File: tsxl_pkg.sv */
// Purpose: Shared constants for the test-skip / xor-literal execution block
// Assumes: 16-bit instruction words, 8-bit data path, four phases per cycle
// Notes: Register port offsets live here too
package tsxl_pkg;
    localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
    localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
    localparam int TEST_SKIP_OPC_POS = 9;
    localparam int ACCESS_BIT_POS = 8;
    localparam int XOR_OPC_POS = 8;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] TWO_WORD_PREFIX = 4'hf;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [2:0] REG_ACC = 3'h0;
    localparam logic [2:0] REG_BANK = 3'h1;
    localparam logic [2:0] REG_CTRL = 3'h2;
    localparam logic [2:0] REG_FLAGS = 3'h3;
    localparam logic [2:0] REG_INDEX = 3'h4;
    localparam int CTRL_EXT_POS = 0;
    localparam int FLAG_N_POS = 1;
    localparam int FLAG_Z_POS = 0;
    typedef enum logic [3:0] {
        TSXL_Q1 = 4'b0001,
        TSXL_Q2 = 4'b0010,
        TSXL_Q3 = 4'b0100,
        TSXL_Q4 = 4'b1000
    } tsxl_phase_t;
endpackage

/* File: tsxl_phase_gen.sv */
// Purpose: Four-phase instruction cycle sequencer
// Assumes: One phase per clock
// Notes: Q4 wraps to Q1
module tsxl_phase_gen
    import tsxl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Phase
    output tsxl_phase_t phase
);
    tsxl_phase_t phase_q;
    assign phase = phase_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= TSXL_Q1;
        end
        else
        begin
            case (phase_q)
                TSXL_Q1: phase_q <= TSXL_Q2;
                TSXL_Q2: phase_q <= TSXL_Q3;
                TSXL_Q3: phase_q <= TSXL_Q4;
                default: phase_q <= TSXL_Q1;
            endcase
        end
    end
endmodule

/* File: tsxl_exec.sv */
// Purpose: Executes test-register-skip-if-zero and xor-literal-into-accumulator
// Assumes: Instruction word and register read data valid through a cycle
// Notes: Register port gives software access to accumulator, bank and flags
// Notes on behaviour
// - Zero operand flushes next word, no flags
// - Skipped two-word instruction costs three cycles
// - Access bit picks access bank or bank
// - Extended mode indexes operands up to 95
// - Xor literal with accumulator, set N, Z
// - Result back to accumulator, one cycle
module tsxl_exec
    import tsxl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction stream
    input wire logic [15:0] instr_word,
    // Data register file
    output logic [11:0] file_addr,
    output logic file_rd,
    input wire logic [7:0] file_rdata,
    // Core state
    output logic [7:0] acc_out,
    output logic flag_n,
    output logic flag_z,
    output logic flush,
    output logic cycle_start,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    tsxl_phase_t phase;
    logic [15:0] ir_q;
    logic [7:0] acc_q;
    logic [7:0] result_q;
    logic [3:0] bank_q;
    logic ext_en_q;
    logic [7:0] index_q;
    logic n_q;
    logic z_q;
    logic [1:0] flush_cnt_q;
    logic flush_q;
    logic [11:0] file_addr_q;
    logic file_rd_q;
    logic op_zero_q;
    logic [7:0] reg_rdata_q;
    logic cycle_start_q;
    logic is_skip;
    logic is_xor;
    logic [7:0] f_field;
    logic [11:0] addr_d;
    logic next_two_word;

    tsxl_phase_gen u_phase
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .phase(phase)
    );

    assign is_skip = (ir_q[15:TEST_SKIP_OPC_POS] == OPC_TEST_SKIP) && !flush_q;
    assign is_xor = (ir_q[15:XOR_OPC_POS] == OPC_XOR_LIT) && !flush_q;
    assign f_field = ir_q[7:0];
    assign next_two_word = (instr_word[15:12] == TWO_WORD_PREFIX);

    // Operand address selection
    always_comb
    begin
        if (ir_q[ACCESS_BIT_POS])
        begin
            addr_d = {bank_q, f_field};
        end
        else if (ext_en_q && (f_field <= INDEXED_LIMIT))
        begin
            addr_d = {4'h0, 8'(index_q + f_field)};
        end
        else if (f_field < ACCESS_SPLIT)
        begin
            addr_d = {4'h0, f_field};
        end
        else
        begin
            addr_d = {ACCESS_HIGH_BANK, f_field};
        end
    end

    // Decode: latch instruction at Q1
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_q <= 16'h0000;
            cycle_start_q <= 1'b0;
        end
        else
        begin
            cycle_start_q <= (phase == TSXL_Q4);
            if (phase == TSXL_Q1)
            begin
                ir_q <= instr_word;
            end
        end
    end

    // Read operand at Q2
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            file_addr_q <= 12'h000;
            file_rd_q <= 1'b0;
            op_zero_q <= 1'b0;
        end
        else
        begin
            file_rd_q <= (phase == TSXL_Q2) && is_skip;
            // Operand only valid while the read strobe stands
            if (file_rd_q)
            begin
                op_zero_q <= (file_rdata == 8'h00);
            end
            if ((phase == TSXL_Q2) && is_skip)
            begin
                file_addr_q <= addr_d;
            end
        end
    end

    // Process at Q3
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_q <= 8'h00;
        end
        else if ((phase == TSXL_Q3) && is_xor)
        begin
            result_q <= acc_q ^ ir_q[7:0];
        end
    end

    // Skip control: flush one or two following words
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flush_cnt_q <= 2'd0;
            flush_q <= 1'b0;
        end
        else if (phase == TSXL_Q4)
        begin
            if (is_skip && op_zero_q)
            begin
                flush_q <= 1'b1;
                flush_cnt_q <= next_two_word ? 2'd2 : 2'd1;
            end
            else if (flush_cnt_q > 2'd1)
            begin
                flush_q <= 1'b1;
                flush_cnt_q <= flush_cnt_q - 2'd1;
            end
            else
            begin
                flush_q <= 1'b0;
                flush_cnt_q <= 2'd0;
            end
        end
    end

    // Write destination at Q4; skip and flushed cycles leave state alone
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= ACC_RESET;
            n_q <= 1'b0;
            z_q <= 1'b0;
        end
        else if ((phase == TSXL_Q4) && is_xor)
        begin
            acc_q <= result_q;
            n_q <= result_q[7];
            z_q <= (result_q == 8'h00);
        end
        else if (reg_wr && (reg_addr == REG_ACC))
        begin
            acc_q <= reg_wdata;
        end
        else if (reg_wr && (reg_addr == REG_FLAGS))
        begin
            n_q <= reg_wdata[FLAG_N_POS];
            z_q <= reg_wdata[FLAG_Z_POS];
        end
    end

    // Software registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank_q <= BANK_RESET;
            ext_en_q <= 1'b0;
            index_q <= 8'h00;
        end
        else if (reg_wr)
        begin
            if (reg_addr == REG_BANK)
            begin
                bank_q <= reg_wdata[3:0];
            end
            else if (reg_addr == REG_CTRL)
            begin
                ext_en_q <= reg_wdata[CTRL_EXT_POS];
            end
            else if (reg_addr == REG_INDEX)
            begin
                index_q <= reg_wdata;
            end
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == REG_ACC)
            begin
                reg_rdata_q <= acc_q;
            end
            else if (reg_addr == REG_BANK)
            begin
                reg_rdata_q <= {4'h0, bank_q};
            end
            else if (reg_addr == REG_CTRL)
            begin
                reg_rdata_q <= {7'h00, ext_en_q};
            end
            else if (reg_addr == REG_FLAGS)
            begin
                reg_rdata_q <= {5'h00, flush_q, n_q, z_q};
            end
            else if (reg_addr == REG_INDEX)
            begin
                reg_rdata_q <= index_q;
            end
            else
            begin
                reg_rdata_q <= 8'h00;
            end
        end
        else
        begin
            reg_rdata_q <= 8'h00;
        end
    end

    assign acc_out = acc_q;
    assign flag_n = n_q;
    assign flag_z = z_q;
    assign flush = flush_q;
    assign file_addr = file_addr_q;
    assign file_rd = file_rd_q;
    assign reg_rdata = reg_rdata_q;
    assign cycle_start = cycle_start_q;
endmodule

/* File: tsxl_exec_monitor.sv */
// Purpose: Port checks for the test-skip / xor-literal block
// Assumes: Software leaves the accumulator alone
// Notes: Bound to tsxl_exec below
module tsxl_exec_monitor
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Observed ports
    input wire logic file_rd,
    input wire logic [7:0] file_rdata,
    input wire logic flush,
    input wire logic [7:0] acc_out,
    input wire logic flag_n,
    input wire logic flag_z,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence zero_seen;
        file_rd && file_rdata == 8'h00;
    endsequence
    sequence nonzero_seen;
        file_rd && file_rdata != 8'h00;
    endsequence
    skip_flush_a: assert property (zero_seen |-> ##2 flush [*4])
        else $error("no flush after zero operand");
    no_skip_a: assert property (nonzero_seen |-> ##2 !flush)
        else $error("flush after nonzero operand");
    skip_flags_a: assert property (file_rd |-> ##2 $stable({flag_n, flag_z}))
        else $error("flags moved on test skip");
    rd_pulse_a: assert property (file_rd |=> !file_rd)
        else $error("operand read too long");
    flush_quiet_a: assert property (flush |-> !file_rd)
        else $error("read while flushing");
    acc_hold_a: assert property (flush |=> $stable({acc_out, flag_n, flag_z}))
        else $error("state changed while flushing");
    flags_track_a: assert property ($changed(acc_out) |->
        flag_z == (acc_out == 8'h00) && flag_n == acc_out[7])
        else $error("flags disagree with accumulator");
    one_write_a: assert property ($changed(acc_out) |=> $stable(acc_out) [*3])
        else $error("accumulator written twice in a cycle");
    rdata_idle_a: assert property ((!reg_rd || reg_addr > 3'h4) |=> reg_rdata == 8'h00)
        else $error("read data not zero");
endmodule

bind tsxl_exec tsxl_exec_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .file_rd(file_rd),
    .file_rdata(file_rdata), .flush(flush), .acc_out(acc_out), .flag_n(flag_n),
    .flag_z(flag_z), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata));

/* File: tsxl_file_model.sv */
// Purpose: Data register file behind the operand port
// Assumes: Read data combinational while the read strobe is high
// Notes: Released data shows the inverse of the last byte
module tsxl_file_model
(
    // Clock
    input wire logic sys_clk,
    // Read port
    input wire logic [11:0] file_addr,
    input wire logic file_rd,
    output logic [7:0] file_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    logic [7:0] last_q = 8'h00;
    assign file_rdata = file_rd ? mem[file_addr] : ~last_q;
    always_ff @(posedge sys_clk)
    begin
        if (file_rd)
        begin
            last_q <= mem[file_addr];
        end
    end
endmodule

/* File: tsxl_exec_tb_top.sv */
// Purpose: Random instruction stream against a reference model
// Assumes: One instruction per four clocks, next word prefetched
// Notes: Registers set between batches
module tsxl_exec_tb_top;
    import tsxl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, file_rd, flag_n, flag_z, flush;
    logic [15:0] instr_word = 0, cur = 0;
    logic [11:0] file_addr;
    logic [7:0] file_rdata, acc_out, reg_rdata, reg_wdata = 0, acc = 0, idx;
    logic [2:0] reg_addr = 0;
    logic [3:0] bank;
    logic ext, cs, n = 0, z = 0;
    int fl = 0, miscompares = 0, checks = 0, cyc_n = 0;
    tsxl_exec u_tsxl_exec (.sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
        .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .acc_out(acc_out),
        .flag_n(flag_n), .flag_z(flag_z), .flush(flush), .cycle_start(cs), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    tsxl_file_model u_tsxl_file_model (.sys_clk(sys_clk), .file_addr(file_addr),
        .file_rd(file_rd), .file_rdata(file_rdata));
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            miscompares++;
            conclude();
        end
    end
    task chk(string nm, logic [11:0] s, logic [11:0] e);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task op(logic w, logic r, logic [2:0] a, logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask
    function logic [11:0] ea(logic a, logic [7:0] f);
        if (a)
            return {bank, f};
        if (ext && f <= INDEXED_LIMIT)
            return 12'(idx) + 12'(f);
        return {(f >= ACCESS_SPLIT) ? ACCESS_HIGH_BANK : 4'h0, f};
    endfunction
    // Runs the current word, prefetches nx, then compares with the model
    task cyc(logic [15:0] nx);
        @(posedge sys_clk);
        instr_word <= nx;
        repeat (3) @(posedge sys_clk);
        #1;
        if (fl > 0)
            fl--;
        else if (cur[15:9] == OPC_TEST_SKIP)
        begin
            chk("file_addr", file_addr, ea(cur[8], cur[7:0]));
            if (u_tsxl_file_model.mem[ea(cur[8], cur[7:0])] == 8'h00)
                fl = (nx[15:12] == TWO_WORD_PREFIX) ? 2 : 1;
        end
        else if (cur[15:8] == OPC_XOR_LIT)
        begin
            acc ^= cur[7:0];
            n = acc[7];
            z = (acc == 8'h00);
        end
        cur = nx;
        chk("acc", acc_out, acc);
        chk("flags", {flag_n, flag_z}, {n, z});
        chk("flush", flush, fl > 0);
        chk("cycle_start", cs, 1'b1);
    endtask
    task cfg;
        repeat (3) cyc(16'h0000);
        bank = 4'($urandom);
        ext = 1'($urandom);
        idx = 8'($urandom % 161);
        op(1, 0, REG_BANK, 8'(bank));
        op(1, 0, REG_CTRL, 8'(ext) << CTRL_EXT_POS);
        op(1, 0, REG_INDEX, idx);
        op(0, 1, REG_ACC, 8'h00);
        #1;
        chk("acc reg", reg_rdata, acc);
        op(0, 1, REG_FLAGS, 8'h00);
        #1;
        chk("flag reg", reg_rdata, {1'b0, n, z});
        op(0, 1, REG_BANK, 8'h00);
        #1;
        chk("bank reg", reg_rdata, bank);
        op(0, 1, REG_INDEX, 8'h00);
        #1;
        chk("index reg", reg_rdata, idx);
        op(0, 1, 3'h7, 8'h00);
        #1;
        chk("unmapped", reg_rdata, 12'h000);
        reg_rd <= 1'b0;
    endtask
    initial
    begin
        void'($urandom(98));
        for (int i = 0; i < 4096; i++)
            u_tsxl_file_model.mem[i] = ($urandom % 2) ? 8'h00 : 8'($urandom);
        repeat (3) @(posedge sys_clk);
        rst_n <= 1;
        for (int t = 0; t < 6; t++)
        begin
            cfg();
            for (int i = 0; i < 40; i++)
            begin
                case ($urandom % 4)
                    0: cyc({OPC_XOR_LIT, i[0] ? acc : 8'($urandom)});
                    1: cyc({TWO_WORD_PREFIX, 12'($urandom)});
                    default: cyc({OPC_TEST_SKIP, 9'($urandom)});
                endcase
            end
            $display("batch %0d done", t);
        end
        conclude();
    end
endmodule
